// File: fosl_pkg.sv
// constants for the fibre optic status link: timing, tones, decode values and latch layout
package fosl_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   // tone frequencies: zero is the high tone, one the low tone
   localparam int unsigned TONE_ZERO_HZ = 300_000;
   localparam int unsigned TONE_ONE_HZ = 150_000;
   localparam int unsigned ZERO_HALF_CYC = CLK_HZ / (2 * TONE_ZERO_HZ);
   localparam int unsigned ONE_HALF_CYC = CLK_HZ / (2 * TONE_ONE_HZ);
   // receive windows allow a quarter of a half period either way
   localparam int unsigned ZERO_MIN_CYC = (ZERO_HALF_CYC * 3) / 4;
   localparam int unsigned ZERO_MAX_CYC = (ZERO_HALF_CYC * 5) / 4;
   localparam int unsigned ONE_MIN_CYC = (ONE_HALF_CYC * 3) / 4;
   localparam int unsigned ONE_MAX_CYC = (ONE_HALF_CYC * 5) / 4;
   // half periods that make one bit, in quarter-bit units
   localparam logic [2:0] ZERO_HALF_QTR = 3'h1;
   localparam logic [2:0] ONE_HALF_QTR = 3'h2;
   localparam logic [2:0] BIT_QTR = 3'h4;
   // frame gap sent by the transmitter and gap that resyncs the receiver
   localparam int unsigned TX_GAP_NS = 12_000;
   localparam int unsigned RX_GAP_NS = 8_000;
   localparam int unsigned TX_GAP_CYC = (TX_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned RX_GAP_CYC = (RX_GAP_NS * (CLK_HZ / 1_000_000)) / 1000;
   // silence on the fibre that counts as a dead link
   localparam int unsigned LOSS_US = 200;
   localparam int unsigned LOSS_CYC = LOSS_US * (CLK_HZ / 1_000_000);
   // activity indicator
   localparam int unsigned TX_HOLD_S = 16;
   localparam int unsigned TX_HOLD_CYC = TX_HOLD_S * CLK_HZ;
   localparam int unsigned RX_HOLD_MS = 250;
   localparam int unsigned RX_HOLD_CYC = RX_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_HZ = 8;
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
   // channels per frame and latch bit positions
   localparam int unsigned FRAME_BITS = 4;
   localparam int unsigned ST_PARITY_BIT = 0;
   localparam int unsigned ST_BUSY_BIT = 1;
   localparam int unsigned ST_READY_A_BIT = 2;
   localparam int unsigned ST_READY_B_BIT = 3;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   // chip select decode of address bits 7..3 for the printer-side peripherals
   localparam logic [4:0] SEL_PARALLEL = 5'h0A;
   localparam logic [4:0] SEL_TIMER = 5'h0B;
   localparam logic [4:0] SEL_SERIAL = 5'h0C;
   typedef enum logic [1:0] {
      FOSL_TX_GAP = 2'b01,
      FOSL_TX_SEND = 2'b10
   } fosl_tx_state_t;
endpackage : fosl_pkg

// File: fosl_link.sv
// printer-side fibre optic link: fsk transmitter, receiver, signal detector, activity led, decode
`timescale 1ns/10ps
module fosl_link
   import fosl_pkg::*;
#(
   parameter int unsigned TX_HOLD_LEN = TX_HOLD_CYC,
   parameter int unsigned RX_HOLD_LEN = RX_HOLD_CYC,
   parameter int unsigned BLINK_LEN = BLINK_HALF_CYC,
   parameter int unsigned LOSS_LEN = LOSS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic dataToPrinter,
   input wire logic motorEnable,
   input wire logic txBitClock,
   input wire logic strapTxClock,
   input wire logic fibreRxTone,
   input wire logic opticOverdrive,
   input wire logic opticQualityLow,
   input wire logic [7:0] busAddr,
   input wire logic periphPhase2,
   output logic fibreTxTone,
   output logic parityErrorIn,
   output logic printerBusy,
   output logic printerReadyA,
   output logic printerReadyB,
   output logic faultLed,
   output logic activityLed,
   output logic csParallel,
   output logic csTimer,
   output logic csSerial
);
   // pin synchronisers: three stages, a change is taken when stages two and three agree
   localparam int unsigned NSYNC = 7;
   logic [NSYNC-1:0] syncA, syncB, syncC, pinStable, pinPrev;
   logic dataS, enableS, dataEdge, txClkRise, rxEdge, strapSel, txTrigger;
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA <= '0;
         syncB <= '0;
         syncC <= '0;
         pinStable <= '0;
         pinPrev <= '0;
      end else begin
         syncA <= {strapTxClock, opticQualityLow, opticOverdrive, fibreRxTone, txBitClock, motorEnable, dataToPrinter};
         syncB <= syncA;
         syncC <= syncB;
         pinStable <= (syncB & syncC) | (pinStable & (syncB | syncC));
         pinPrev <= pinStable;
      end
   end
   // the strap is a pin too; a change only matters at the next trigger
   assign strapSel = pinStable[6];
   assign dataS = pinStable[0];
   assign enableS = pinStable[1];
   assign dataEdge = pinStable[0] ^ pinPrev[0];
   assign txClkRise = pinStable[2] & ~pinPrev[2];
   assign rxEdge = pinStable[3] ^ pinPrev[3];
   function automatic logic [15:0] halfLen(input logic b);
      halfLen = b ? 16'(ONE_HALF_CYC) : 16'(ZERO_HALF_CYC);
   endfunction : halfLen
   function automatic logic [2:0] halfQtr(input logic b);
      halfQtr = b ? ONE_HALF_QTR : ZERO_HALF_QTR;
   endfunction : halfQtr
   function automatic logic selHit(input logic en, input logic [7:0] addr, input logic [4:0] v);
      selHit = en && addr[7:3] == v;
   endfunction : selHit
   fosl_tx_state_t txState;
   logic [3:0] txShift;
   logic [1:0] txBitIdx;
   logic [2:0] txHalves;
   logic [15:0] txTimer;
   assign txTrigger = strapSel ? txClkRise : dataEdge;
   always_ff @(posedge clk) begin
      if (rst) begin
         txState <= FOSL_TX_GAP;
         txShift <= 4'h0;
         txBitIdx <= 2'h0;
         txHalves <= 3'h0;
         txTimer <= 16'h0000;
         fibreTxTone <= 1'b0;
      end else if (txTrigger) begin
         // restart the frame so the fresh sample goes out after one gap
         txState <= FOSL_TX_GAP;
         txTimer <= 16'h0000;
         fibreTxTone <= 1'b0;
      end else begin
         case (txState)
            FOSL_TX_GAP: begin
               if (txTimer >= 16'(TX_GAP_CYC - 1)) begin
                  // four channels: data, enable, two spare sent as zero
                  txShift <= {2'b00, enableS, dataS};
                  txBitIdx <= 2'h0;
                  txHalves <= 3'h0;
                  txTimer <= 16'h0000;
                  txState <= FOSL_TX_SEND;
               end else begin
                  txTimer <= txTimer + 16'h0001;
               end
            end
            FOSL_TX_SEND: begin
               if (txTimer >= halfLen(txShift[0]) - 16'h0001) begin
                  txTimer <= 16'h0000;
                  fibreTxTone <= ~fibreTxTone;
                  if (txHalves + halfQtr(txShift[0]) >= BIT_QTR) begin
                     txHalves <= 3'h0;
                     txShift <= {1'b0, txShift[3:1]};
                     txBitIdx <= txBitIdx + 2'h1;
                     if (txBitIdx == 2'(FRAME_BITS - 1)) begin
                        txState <= FOSL_TX_GAP;
                     end
                  end else begin
                     txHalves <= txHalves + halfQtr(txShift[0]);
                  end
               end else begin
                  txTimer <= txTimer + 16'h0001;
               end
            end
            default: begin
               txState <= FOSL_TX_GAP;
               txTimer <= 16'h0000;
               fibreTxTone <= 1'b0;
            end
         endcase
      end
   end
   // each half period is classified by length; a bit is four quarters of one kind
   logic [15:0] rxTimer;
   logic [2:0] rxQtr, addQtr;
   logic [1:0] rxBitCnt;
   logic [3:0] rxShift, statusLatch;
   logic rxKind, rxFrameDone, toneBad, toneFault, halfZero, halfOne, halfGap, sigFault;
   assign halfZero = rxTimer >= 16'(ZERO_MIN_CYC) && rxTimer <= 16'(ZERO_MAX_CYC);
   assign halfOne = rxTimer >= 16'(ONE_MIN_CYC) && rxTimer <= 16'(ONE_MAX_CYC);
   assign halfGap = rxTimer >= 16'(RX_GAP_CYC);
   assign addQtr = halfQtr(halfOne);
   always_ff @(posedge clk) begin
      if (rst) begin
         rxTimer <= 16'h0000;
         rxQtr <= 3'h0;
         rxKind <= 1'b0;
         rxBitCnt <= 2'h0;
         rxShift <= 4'h0;
         rxFrameDone <= 1'b0;
         toneBad <= 1'b0;
      end else begin
         rxFrameDone <= 1'b0;
         toneBad <= 1'b0;
         if (!rxEdge) begin
            if (rxTimer != 16'hFFFF) begin
               rxTimer <= rxTimer + 16'h0001;
            end
         end else begin
            rxTimer <= 16'h0000;
            if (halfGap) begin
               // long quiet: next half starts a new frame
               rxQtr <= 3'h0;
               rxBitCnt <= 2'h0;
            end else if ((halfZero || halfOne) && (rxQtr == 3'h0 || rxKind == halfOne)) begin
               rxKind <= halfOne;
               if (rxQtr + addQtr >= BIT_QTR) begin
                  rxQtr <= 3'h0;
                  rxShift <= {halfOne, rxShift[3:1]};
                  rxBitCnt <= rxBitCnt + 2'h1;
                  rxFrameDone <= rxBitCnt == 2'(FRAME_BITS - 1);
               end else begin
                  rxQtr <= rxQtr + addQtr;
               end
            end else begin
               // wrong length or a mixed bit: invalid tone pattern
               toneBad <= 1'b1;
               rxQtr <= 3'h0;
               rxBitCnt <= 2'h0;
            end
         end
      end
   end
   // silence watchdog: no edge for a long time means the far unit or the cable is gone
   logic [31:0] lossCnt;
   always_ff @(posedge clk) begin
      if (rst || rxEdge) begin
         lossCnt <= 32'h00000000;
      end else if (lossCnt != LOSS_LEN) begin
         lossCnt <= lossCnt + 32'h00000001;
      end
   end
   // a clean frame ends a tone fault by itself
   always_ff @(posedge clk) begin
      if (rst) begin
         toneFault <= 1'b0;
      end else if (toneBad || lossCnt == LOSS_LEN) begin
         toneFault <= 1'b1;
      end else if (rxFrameDone) begin
         toneFault <= 1'b0;
      end
   end
   assign sigFault = pinStable[4] | pinStable[5] | toneFault;
   always_ff @(posedge clk) begin
      if (rst) begin
         faultLed <= 1'b0;
      end else begin
         faultLed <= sigFault;
      end
   end
   // status latch, order fixed by bit position
   always_ff @(posedge clk) begin
      if (rst || sigFault) begin
         statusLatch <= STATUS_RESET;
      end else if (rxFrameDone) begin
         statusLatch <= rxShift;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         parityErrorIn <= 1'b0;
         printerBusy <= 1'b0;
         printerReadyA <= 1'b0;
         printerReadyB <= 1'b0;
      end else begin
         parityErrorIn <= statusLatch[ST_PARITY_BIT];
         printerBusy <= statusLatch[ST_BUSY_BIT];
         printerReadyA <= statusLatch[ST_READY_A_BIT];
         printerReadyB <= statusLatch[ST_READY_B_BIT];
      end
   end
   logic [31:0] txHold, rxHold, blinkCnt;
   logic blinkPhase, rxDataChange;
   assign rxDataChange = rxFrameDone && !sigFault && rxShift[ST_PARITY_BIT] != statusLatch[ST_PARITY_BIT];
   always_ff @(posedge clk) begin
      if (rst) begin
         txHold <= 32'h00000000;
      end else if (dataEdge) begin
         txHold <= TX_HOLD_LEN;
      end else if (txHold != 32'h00000000) begin
         txHold <= txHold - 32'h00000001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rxHold <= 32'h00000000;
      end else if (rxDataChange) begin
         rxHold <= RX_HOLD_LEN;
      end else if (rxHold != 32'h00000000) begin
         rxHold <= rxHold - 32'h00000001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         blinkCnt <= 32'h00000000;
         blinkPhase <= 1'b0;
      end else if (blinkCnt >= BLINK_LEN - 1) begin
         blinkCnt <= 32'h00000000;
         blinkPhase <= ~blinkPhase;
      end else begin
         blinkCnt <= blinkCnt + 32'h00000001;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         activityLed <= 1'b0;
      end else if (txHold != 32'h00000000) begin
         activityLed <= 1'b1;
      end else if (rxHold != 32'h00000000) begin
         activityLed <= blinkPhase;
      end else begin
         activityLed <= 1'b0;
      end
   end
   // registered, so selects trail the address by one clock; phase two lasts many clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         csParallel <= 1'b0;
         csTimer <= 1'b0;
         csSerial <= 1'b0;
      end else begin
         csParallel <= selHit(periphPhase2, busAddr, SEL_PARALLEL);
         csTimer <= selHit(periphPhase2, busAddr, SEL_TIMER);
         csSerial <= selHit(periphPhase2, busAddr, SEL_SERIAL);
      end
   end
endmodule : fosl_link

// File: fosl_link_chk.sv
// port-level assertions for the fibre optic status link
`timescale 1ns/10ps
module fosl_link_chk
   import fosl_pkg::*;
#(
   parameter int unsigned TX_HOLD_LEN = TX_HOLD_CYC,
   parameter int unsigned RX_HOLD_LEN = RX_HOLD_CYC,
   parameter int unsigned BLINK_LEN = BLINK_HALF_CYC,
   parameter int unsigned LOSS_LEN = LOSS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic dataToPrinter,
   input wire logic fibreRxTone,
   input wire logic opticOverdrive,
   input wire logic opticQualityLow,
   input wire logic [7:0] busAddr,
   input wire logic periphPhase2,
   input wire logic fibreTxTone,
   input wire logic parityErrorIn,
   input wire logic printerBusy,
   input wire logic printerReadyA,
   input wire logic printerReadyB,
   input wire logic faultLed,
   input wire logic activityLed,
   input wire logic csParallel,
   input wire logic csTimer,
   input wire logic csSerial
);
   logic lastTx, lastD, lastR;
   logic [31:0] txRun, dRun, rRun;
   logic [3:0] status;
   assign status = {printerReadyB, printerReadyA, printerBusy, parityErrorIn};
   always_ff @(posedge clk) begin
      lastTx <= fibreTxTone;
      lastD <= dataToPrinter;
      lastR <= fibreRxTone;
   end
   // data and receive ages start saturated so the idle rule applies right after reset
   always_ff @(posedge clk) begin
      txRun <= (rst || fibreTxTone != lastTx) ? 32'h0 : txRun + 32'h1;
      dRun <= rst ? 32'hFFFFFFFF : (dataToPrinter != lastD) ? 32'h0 : dRun + {31'h0, dRun != 32'hFFFFFFFF};
      rRun <= rst ? 32'hFFFFFFFF : (fibreRxTone != lastR) ? 32'h0 : rRun + {31'h0, rRun != 32'hFFFFFFFF};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_sel(logic cs, logic [4:0] v);
      !$past(rst) |-> cs == $past(periphPhase2 && busAddr[7:3] == v);
   endproperty
   cs_parallel_a: assert property (p_sel(csParallel, SEL_PARALLEL)) else $error("parallel select wrong");
   cs_timer_a: assert property (p_sel(csTimer, SEL_TIMER)) else $error("timer select wrong");
   cs_serial_a: assert property (p_sel(csSerial, SEL_SERIAL)) else $error("serial select wrong");
   tx_half_a: assert property ($rose(fibreTxTone) |-> txRun == ZERO_HALF_CYC - 1 || txRun == ONE_HALF_CYC - 1
      || txRun >= TX_GAP_CYC - 1) else $error("transmit tone half of wrong length");
   fault_latch_a: assert property (faultLed && $past(faultLed) |-> status == STATUS_RESET)
      else $error("status held during fault");
   fault_input_a: assert property ((opticOverdrive || opticQualityLow) [*8] |-> faultLed)
      else $error("optic fault not shown");
   loss_fault_a: assert property (rRun == LOSS_LEN + 8 |-> faultLed) else $error("dead link not shown");
   status_cause_a: assert property ($changed(status) && status != 4'h0 |-> rRun < 12)
      else $error("status changed without a frame");
   led_dark_a: assert property (dRun > TX_HOLD_LEN + 16 && rRun > RX_HOLD_LEN + 16 |-> !activityLed)
      else $error("activity lit while idle");
   led_tx_a: assert property (!$past(rst) && $changed(dataToPrinter) |-> ##6 activityLed [*8])
      else $error("activity not lit on transmit");
   cover property ($rose(faultLed));
   cover property ($rose(csSerial));
   cover property ($changed(status) && status != 4'h0);
endmodule : fosl_link_chk
bind fosl_link fosl_link_chk #(.TX_HOLD_LEN(TX_HOLD_LEN), .RX_HOLD_LEN(RX_HOLD_LEN), .BLINK_LEN(BLINK_LEN),
   .LOSS_LEN(LOSS_LEN)) i_chk (.clk, .rst, .dataToPrinter, .fibreRxTone, .opticOverdrive, .opticQualityLow,
   .busAddr, .periphPhase2, .fibreTxTone, .parityErrorIn, .printerBusy, .printerReadyA, .printerReadyB,
   .faultLed, .activityLed, .csParallel, .csTimer, .csSerial);

// File: fosl_far_unit.sv
// behavioural far-end unit that sends printer status frames on the receive fibre
`timescale 1ns/10ps
module fosl_far_unit
   import fosl_pkg::*;
(
   input wire logic clk,
   output logic tone
);
   initial tone = 1'b0;
   task automatic half(input int unsigned len);
      repeat (len) @(negedge clk);
      tone = ~tone;
   endtask : half
   // one edge ends the quiet gap so the first half is timed; the idle level alternates per frame
   task automatic send(input logic [3:0] bits);
      repeat (1100) @(negedge clk);
      tone = ~tone;
      for (int i = 0; i < 4; i++) begin
         repeat (bits[i] ? 2 : 4) half(bits[i] ? ONE_HALF_CYC : ZERO_HALF_CYC);
      end
   endtask : send
   // a half far too short for either tone
   task automatic bad();
      repeat (1100) @(negedge clk);
      repeat (2) half(60);
   endtask : bad
endmodule : fosl_far_unit

// File: test_fibre_optic_status_link.sv
// self-checking bench for the fibre optic status link
`timescale 1ns/10ps
module test_fibre_optic_status_link;
   import fosl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic dataToPrinter = 1'b0;
   logic motorEnable = 1'b0;
   logic txBitClock = 1'b0;
   logic strapTxClock = 1'b0;
   logic opticOverdrive = 1'b0;
   logic opticQualityLow = 1'b0;
   logic [7:0] busAddr = 8'h00;
   logic periphPhase2 = 1'b0;
   logic fibreRxTone, fibreTxTone, parityErrorIn, printerBusy, printerReadyA, printerReadyB;
   logic faultLed, activityLed, csParallel, csTimer, csSerial;
   logic [3:0] status;
   int failCount = 0;
   int checks = 0;
   assign status = {printerReadyB, printerReadyA, printerBusy, parityErrorIn};
   always #4 clk = ~clk;
   fosl_far_unit i_far (.clk, .tone(fibreRxTone));
   fosl_link #(.TX_HOLD_LEN(2000), .RX_HOLD_LEN(1000), .BLINK_LEN(50), .LOSS_LEN(3000)) i_dut (.clk, .rst,
      .dataToPrinter, .motorEnable, .txBitClock, .strapTxClock, .fibreRxTone, .opticOverdrive, .opticQualityLow,
      .busAddr, .periphPhase2, .fibreTxTone, .parityErrorIn, .printerBusy, .printerReadyA, .printerReadyB,
      .faultLed, .activityLed, .csParallel, .csTimer, .csSerial);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   task automatic t_decode();
      logic [4:0] a;
      for (int i = 0; i < 64; i++) begin
         a = i[4:0];
         busAddr = {a, 3'h5};
         periphPhase2 = i[5];
         repeat (2) @(negedge clk);
         check({13'h0, csSerial, csTimer, csParallel}, {13'h0, i[5] && a == SEL_SERIAL, i[5] && a == SEL_TIMER,
            i[5] && a == SEL_PARALLEL});
      end
      periphPhase2 = 1'b0;
      $display("decode test done");
   endtask : t_decode
   // two frames per pattern: the first may only end a leftover tone fault
   task automatic t_rx();
      logic [3:0] pats [3] = '{4'h5, 4'hA, 4'h3};
      foreach (pats[k]) begin
         repeat (2) i_far.send(pats[k]);
         repeat (10) @(negedge clk);
         check({11'h0, faultLed, status}, {12'h0, pats[k]});
      end
      $display("receive test done");
   endtask : t_rx
   task automatic t_blink();
      int ones = 0;
      i_far.send(4'h2);
      repeat (6) @(negedge clk);
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         ones += (activityLed === 1'b1);
      end
      check({15'h0, ones > 60 && ones < 140}, 16'h0001);
      repeat (1100) @(negedge clk);
      check({15'h0, activityLed}, 16'h0000);
      $display("blink test done");
   endtask : t_blink
   task automatic t_fault();
      for (int k = 0; k < 3; k++) begin
         opticOverdrive = (k == 0);
         opticQualityLow = (k == 1);
         if (k == 2) i_far.bad();
         repeat (8) @(negedge clk);
         check({faultLed, 11'h0, status}, 16'h8000);
         opticOverdrive = 1'b0;
         opticQualityLow = 1'b0;
         repeat (2) i_far.send(4'h9);
         repeat (10) @(negedge clk);
         check({faultLed, 11'h0, status}, 16'h0009);
      end
      $display("fault test done");
   endtask : t_fault
   task automatic t_tx(input logic strap, input logic d, input logic m);
      logic [15:0] q[$];
      logic [3:0] bits;
      logic lvl;
      int n;
      bits = {2'b00, m, d};
      for (int i = 0; i < 4; i++) begin
         repeat (bits[i] ? 2 : 4) q.push_back(bits[i] ? 16'(ONE_HALF_CYC) : 16'(ZERO_HALF_CYC));
      end
      strapTxClock = strap;
      motorEnable = m;
      repeat (10) @(negedge clk);
      // the transmit clock pulses in both modes; without the strap only the data change may trigger
      txBitClock = ~txBitClock;
      if (!strap) dataToPrinter = d;
      repeat (10) @(negedge clk);
      txBitClock = ~txBitClock;
      n = 0;
      while (fibreTxTone !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      check({15'h0, fibreTxTone}, 16'h0001);
      if (!strap) check({15'h0, activityLed}, 16'h0001);
      for (int i = 1; i < q.size(); i++) begin
         lvl = fibreTxTone;
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (fibreTxTone === lvl && n < 1000);
         check(n[15:0], q[i]);
      end
      $display("transmit test done");
   endtask : t_tx
   initial begin
      #760_000;
      failCount++;
      $display("BAD at %0t: watchdog expired", $time);
      summarize();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check({6'h0, csParallel, csTimer, csSerial, faultLed, activityLed, fibreTxTone, status}, 16'h0000);
      t_decode();
      t_rx();
      t_blink();
      t_fault();
      t_tx(1'b0, 1'b1, 1'b0);
      t_tx(1'b1, 1'b1, 1'b1);
      check({15'h0, activityLed}, 16'h0000);
      summarize();
   end
endmodule : test_fibre_optic_status_link
